// [verilog/pfm_multiplier.sv]
`timescale 1ns/100ps
// What this block does
// - loop multiplies f by four; dividers give f x1, x2 and x4 candidates
// - field code 00 x1, 01 x2, 10 x4, 11 forbidden selects output clock
// - register cleared only by power-on reset, kept through manual reset, standby
// - upper six bits read zero; software writes zero there
// - selection applies only in clock modes zero through three
// - writing a new value puts chip into temporary internal standby
// - during that standby oscillators run and watchdog is clocked to overflow
// - on watchdog overflow new frequency applies and chip leaves standby
// - modes four to six stop the second loop; multiplier has no effect
module pfm_multiplier (
    // clock and resets
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_n_i,
    input  wire logic                  manual_reset_n_i,
    // register port
    input  wire pfm_pkg::pfm_bus_req_t bus_i,
    output logic [7:0]                 rdata_o,
    // system links
    input  wire logic [2:0]            clock_mode_i,
    input  wire logic                  watchdog_overflow_i,
    output logic                       standby_o,
    output logic                       watchdog_clock_en_o,
    output logic                       loop_enable_o,
    // clock selection, one-hot: x1, x2, x4
    output logic [2:0]                 clk_select_o,
    output logic [2:0]                 loop_ratio_o
);

    pfm_pkg::pfm_state_t state_reg;
    logic [1:0]          code_reg;
    logic [1:0]          applied_reg;
    logic [7:0]          rdata_reg;
    logic [2:0]          mode_s1_reg;
    logic [2:0]          mode_s2_reg;
    logic                ovf_s1_reg;
    logic                ovf_s2_reg;
    logic                loop_modes;
    logic                wr_hit;
    logic                rd_hit;
    logic                bad_write;
    logic [1:0]          wr_code;

    function automatic logic [2:0] onehot(input logic [1:0] c);
        unique case (c)
            pfm_pkg::CODE_X2: onehot = 3'h2;
            pfm_pkg::CODE_X4: onehot = 3'h4;
            default:          onehot = 3'h1;
        endcase
    endfunction

    // the register answers at its one byte address only
    function automatic logic reg_hit(input logic [31:0] a);
        reg_hit = (a == pfm_pkg::MULT_SEL_ADDR);
    endfunction

    // clock mode and watchdog overflow pins pass two flops
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_s1_reg <= 3'h0;
            mode_s2_reg <= 3'h0;
            ovf_s1_reg  <= 1'b0;
            ovf_s2_reg  <= 1'b0;
        end else begin
            mode_s1_reg <= clock_mode_i;
            mode_s2_reg <= mode_s1_reg;
            ovf_s1_reg  <= watchdog_overflow_i;
            ovf_s2_reg  <= ovf_s1_reg;
        end
    end

    assign loop_modes = (mode_s2_reg <= pfm_pkg::LAST_LOOP_MODE);
    assign wr_code    = bus_i.wdata[pfm_pkg::CODE_LSB +: pfm_pkg::CODE_W];
    assign rd_hit     = bus_i.rd && reg_hit(bus_i.addr);
    assign bad_write  = bus_i.wr && reg_hit(bus_i.addr)
                        && (wr_code == pfm_pkg::CODE_BAD);
    assign wr_hit     = bus_i.wr && reg_hit(bus_i.addr) && !bad_write
                        && (wr_code != code_reg) && (state_reg == pfm_pkg::ST_RUN);

    // register: power-on reset only, manual reset ignored
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            code_reg <= pfm_pkg::MULT_SEL_RESET[1:0];
        end else if (wr_hit) begin
            code_reg <= wr_code;
        end
    end

    // change sequence
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_reg   <= pfm_pkg::ST_RUN;
            applied_reg <= pfm_pkg::CODE_X1;
        end else begin
            unique case (state_reg)
                pfm_pkg::ST_RUN: begin
                    if (wr_hit) begin
                        state_reg <= pfm_pkg::ST_SETTLE;
                    end
                end
                pfm_pkg::ST_SETTLE: begin
                    if (ovf_s2_reg) begin
                        applied_reg <= code_reg;
                        state_reg   <= pfm_pkg::ST_RUN;
                    end
                end
            endcase
        end
    end

    // read data one cycle later; upper bits zero
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_reg <= 8'h00;
        end else if (rd_hit) begin
            rdata_reg <= {6'h00, code_reg};
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign rdata_o             = rdata_reg;
    assign standby_o           = (state_reg == pfm_pkg::ST_SETTLE);
    assign watchdog_clock_en_o = (state_reg == pfm_pkg::ST_SETTLE);
    assign loop_enable_o       = loop_modes;
    assign loop_ratio_o        = 3'h4;
    assign clk_select_o        = loop_modes ? onehot(applied_reg) : 3'h1;

    // assertions
    property p_standby_on_write;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_hit |=> standby_o;
    endproperty
    a_standby_on_write: assert property (p_standby_on_write) else $error("no standby");

    property p_wdt_clocked;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        standby_o |-> watchdog_clock_en_o;
    endproperty
    a_wdt_clocked: assert property (p_wdt_clocked) else $error("watchdog unclocked");

    sequence s_settle_ovf;
        standby_o && ovf_s2_reg;
    endsequence
    property p_exit_on_ovf;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_settle_ovf |=> !standby_o && applied_reg == $past(code_reg);
    endproperty
    a_exit_on_ovf: assert property (p_exit_on_ovf) else $error("no apply on overflow");

    property p_hold_in_standby;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (standby_o && !ovf_s2_reg) |=> $stable(applied_reg);
    endproperty
    a_hold_in_standby: assert property (p_hold_in_standby) else $error("early apply");

    property p_read_upper_zero;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |-> rdata_o[7:2] == 6'h00;
    endproperty
    a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper bits set");

    property p_read_value;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        rd_hit |=> rdata_o[1:0] == $past(code_reg);
    endproperty
    a_read_value: assert property (p_read_value) else $error("bad read data");

    property p_no_bad_code;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |-> code_reg != pfm_pkg::CODE_BAD;
    endproperty
    a_no_bad_code: assert property (p_no_bad_code) else $error("forbidden code stored");

    property p_modes_4_6_x1;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !loop_modes |-> clk_select_o == 3'h1 && !loop_enable_o;
    endproperty
    a_modes_4_6_x1: assert property (p_modes_4_6_x1) else $error("loop active in mode 4-6");

    property p_manual_keep;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!manual_reset_n_i && !wr_hit) |=> $stable(code_reg);
    endproperty
    a_manual_keep: assert property (p_manual_keep) else $error("manual reset cleared");

    property p_select_mode;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        loop_modes |-> clk_select_o == onehot(applied_reg);
    endproperty
    a_select_mode: assert property (p_select_mode) else $error("wrong clock selected");

    property p_rdata_idle_zero;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !rd_hit |=> rdata_o == 8'h00;
    endproperty
    a_rdata_idle_zero: assert property (p_rdata_idle_zero) else $error("stray read data");

    property p_bad_keeps_code;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        bad_write |=> $stable(code_reg);
    endproperty
    a_bad_keeps_code: assert property (p_bad_keeps_code) else $error("bad code taken");

    property p_bad_no_standby;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (bad_write && !standby_o) |=> !standby_o;
    endproperty
    a_bad_no_standby: assert property (p_bad_no_standby) else $error("bad code standby");

    property p_busy_write;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (standby_o && bus_i.wr) |=> $stable(code_reg);
    endproperty
    a_busy_write: assert property (p_busy_write) else $error("write in standby");

    property p_code_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !wr_hit |=> $stable(code_reg);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code changed");

    property p_new_code_stored;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        wr_hit |=> code_reg == $past(wr_code);
    endproperty
    a_new_code_stored: assert property (p_new_code_stored) else $error("code not stored");

    property p_stay_running;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!standby_o && !wr_hit) |=> !standby_o;
    endproperty
    a_stay_running: assert property (p_stay_running) else $error("standby without write");

    property p_wdt_only_standby;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        watchdog_clock_en_o |-> standby_o;
    endproperty
    a_wdt_only_standby: assert property (p_wdt_only_standby) else $error("stray clock");

    property p_loop_in_standby;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (standby_o && loop_modes) |-> loop_enable_o;
    endproperty
    a_loop_in_standby: assert property (p_loop_in_standby) else $error("loop stopped");

    sequence s_change_taken;
        wr_hit;
    endsequence
    sequence s_settle_entered;
        standby_o && watchdog_clock_en_o && applied_reg == $past(applied_reg);
    endsequence
    property p_change_walk;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        s_change_taken |=> s_settle_entered;
    endproperty
    a_change_walk: assert property (p_change_walk) else $error("bad change start");

    property p_applied_hold;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        !(standby_o && ovf_s2_reg) |=> $stable(applied_reg);
    endproperty
    a_applied_hold: assert property (p_applied_hold) else $error("applied moved");

    property p_ovf_sync;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        watchdog_overflow_i |-> ##2 ovf_s2_reg;
    endproperty
    a_ovf_sync: assert property (p_ovf_sync) else $error("overflow lost");

    property p_select_x1;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (!loop_modes || applied_reg == pfm_pkg::CODE_X1) |-> clk_select_o == 3'h1;
    endproperty
    a_select_x1: assert property (p_select_x1) else $error("x1 not selected");

    property p_select_x2;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (loop_modes && applied_reg == pfm_pkg::CODE_X2) |-> clk_select_o == 3'h2;
    endproperty
    a_select_x2: assert property (p_select_x2) else $error("x2 not selected");

    property p_select_x4;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        (loop_modes && applied_reg == pfm_pkg::CODE_X4) |-> clk_select_o == 3'h4;
    endproperty
    a_select_x4: assert property (p_select_x4) else $error("x4 not selected");

    property p_select_onehot;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |-> $onehot(clk_select_o);
    endproperty
    a_select_onehot: assert property (p_select_onehot) else $error("select not one-hot");

    property p_ratio_four;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |-> loop_ratio_o == 3'h4;
    endproperty
    a_ratio_four: assert property (p_ratio_four) else $error("loop ratio wrong");

    property p_applied_legal;
        @(posedge sys_clk_i) disable iff (!reset_n_i)
        1'b1 |-> applied_reg != pfm_pkg::CODE_BAD;
    endproperty
    a_applied_legal: assert property (p_applied_legal) else $error("forbidden code applied");

endmodule

// [verilog/pfm_pkg.sv]
package pfm_pkg;

    // register map
    localparam logic [31:0] MULT_SEL_ADDR  = 32'hFFFFFE90;
    localparam logic [7:0]  MULT_SEL_RESET = 8'h00;
    localparam int          CODE_LSB       = 0;
    localparam int          CODE_W         = 2;

    // multiplier codes
    localparam logic [1:0] CODE_X1  = 2'h0;
    localparam logic [1:0] CODE_X2  = 2'h1;
    localparam logic [1:0] CODE_X4  = 2'h2;
    localparam logic [1:0] CODE_BAD = 2'h3;

    // clock mode pins: modes 0..3 use the second loop
    localparam logic [2:0] LAST_LOOP_MODE = 3'h3;

    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } pfm_bus_req_t;

    typedef enum logic [1:0] {
        ST_RUN     = 2'b01,
        ST_SETTLE  = 2'b10
    } pfm_state_t;

endpackage

// [verif/tb_pll_frequency_multiplier.sv]
`timescale 1ns/100ps
module tb_pll_frequency_multiplier;
    logic                  sys_clk_i;
    logic                  reset_n_i;
    logic                  manual_reset_n_i;
    pfm_pkg::pfm_bus_req_t bus_i;
    logic [7:0]            rdata_o;
    logic [2:0]            clock_mode_i;
    logic                  watchdog_overflow_i;
    logic                  standby_o;
    logic                  watchdog_clock_en_o;
    logic                  loop_enable_o;
    logic [2:0]            clk_select_o;
    logic [2:0]            loop_ratio_o;
    logic [7:0]            d;
    int                    mismatches;
    int                    comparisons;
    int                    code;
    int                    mode;
    int                    n;
    int                    i;

    pfm_multiplier u_dut (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .manual_reset_n_i(manual_reset_n_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .clock_mode_i(clock_mode_i),
        .watchdog_overflow_i(watchdog_overflow_i), .standby_o(standby_o),
        .watchdog_clock_en_o(watchdog_clock_en_o), .loop_enable_o(loop_enable_o),
        .clk_select_o(clk_select_o), .loop_ratio_o(loop_ratio_o));

    initial begin
        sys_clk_i = 1'b0;
        forever #25 sys_clk_i = ~sys_clk_i;
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] v);
        @(posedge sys_clk_i);
        bus_i <= '{addr: pfm_pkg::MULT_SEL_ADDR, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_i);
        bus_i.wr <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a);
        @(posedge sys_clk_i);
        bus_i.addr <= a;
        bus_i.rd <= 1'b1;
        @(posedge sys_clk_i);
        bus_i.rd <= 1'b0;
        #1 d = rdata_o;
    endtask

    task automatic check_all();
        rd(pfm_pkg::MULT_SEL_ADDR);
        chk("register", 8'(code), d);
        chk("clk_select", mode > 3 ? 8'h01 : 8'h01 << code, {5'h00, clk_select_o});
        chk("loop_enable", {7'h00, mode <= 3}, {7'h00, loop_enable_o});
        chk("loop_ratio", 8'h04, {5'h00, loop_ratio_o});
    endtask

    // refused codes and unchanged codes must not enter standby
    task automatic change(input int c);
        logic go;
        go = (c != 3) && (c != code);
        wr(8'(c));
        cyc(8);
        chk("standby", {7'h00, go}, {7'h00, standby_o});
        chk("wdt_clock", {7'h00, go}, {7'h00, watchdog_clock_en_o});
        if (go) begin
            wr(8'(c ^ 1));
            cyc(8);
            chk("sel_hold", 8'h01 << code, {5'h00, clk_select_o});
            @(posedge sys_clk_i);
            watchdog_overflow_i <= 1'b1;
            @(posedge sys_clk_i);
            watchdog_overflow_i <= 1'b0;
            n = 0;
            do begin
                cyc(1);
                n++;
            end while (standby_o !== 1'b0 && n < 10);
            // pin edge, two sync flops, then the state register
            chk("standby_cycles", 8'h02, 8'(n));
            chk("standby_end", 8'h00, {7'h00, standby_o});
            code = c;
        end
        check_all();
    endtask

    initial begin
        reset_n_i = 1'b0;
        manual_reset_n_i = 1'b1;
        bus_i = '0;
        clock_mode_i = 3'h0;
        watchdog_overflow_i = 1'b0;
        mismatches = 0;
        comparisons = 0;
        code = 0;
        mode = 0;
        void'($urandom(58981));
        repeat (6) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        cyc(3);
        check_all();
        for (i = 0; i < 4; i++) change(i);
        for (i = 0; i < 12; i++) change($urandom_range(3));
        change(2);
        @(posedge sys_clk_i);
        manual_reset_n_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
        manual_reset_n_i <= 1'b1;
        cyc(2);
        check_all();
        for (i = 0; i < 8; i++) begin
            mode = (i == 7) ? 0 : i;
            @(posedge sys_clk_i);
            clock_mode_i <= 3'(mode);
            cyc(4);
            check_all();
        end
        rd(pfm_pkg::MULT_SEL_ADDR + 32'h00000001);
        chk("unmapped", 8'h00, d);
        change(1);
        @(posedge sys_clk_i);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        code = 0;
        cyc(3);
        check_all();
        stop_test();
    end

    initial begin
        #(50 * 20000);
        mismatches++;
        stop_test();
    end
endmodule
